// ==== rtl/icir_params.svh ====
/*
 * Register offsets, field widths and reset values of the isochronous context
 * interrupt register block. Assumes inclusion by bare name from rtl/.
 */
`ifndef ICIR_PARAMS_SVH
`define ICIR_PARAMS_SVH

`define ICIR_OFF_TX_EVT_SET 8'h90
`define ICIR_OFF_TX_EVT_CLR 8'h94
`define ICIR_OFF_TX_MSK_SET 8'h98
`define ICIR_OFF_TX_MSK_CLR 8'h9c
`define ICIR_OFF_RX_EVT_SET 8'ha0
`define ICIR_OFF_RX_EVT_CLR 8'ha4
`define ICIR_OFF_RX_MSK_SET 8'ha8
`define ICIR_OFF_RX_MSK_CLR 8'hac
`define ICIR_OFF_IRQ_STAT 8'hc0
`define ICIR_OFF_IRQ_MASK 8'hc4
`define ICIR_NUM_TX 8
`define ICIR_NUM_RX 4
`define ICIR_RST_TX 8'h00
`define ICIR_RST_RX 4'h0
`define ICIR_IRQ_W 2
`define ICIR_IRQ_TX_BIT 0
`define ICIR_IRQ_RX_BIT 1
`define ICIR_RST_IRQ 2'h0

`endif

// ==== rtl/icir_pkg.sv ====
/*
 * Types shared by the isochronous context interrupt register block.
 * Assumes icir_params.svh is on the include path.
 */
`include "icir_params.svh"

package icir_pkg;
    typedef logic [`ICIR_NUM_TX-1:0] icir_tx_t;
    typedef logic [`ICIR_NUM_RX-1:0] icir_rx_t;

    // One APB request as seen by the slave.
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [7:0] addr;
        logic [31:0] wdata;
    } icir_apb_req_s;

    // Summary flags handed to the main interrupt event register.
    typedef struct packed {
        logic rx;
        logic tx;
    } icir_summary_s;
endpackage

// ==== rtl/icir_regs.sv ====
/*
 * Isochronous transmit and receive context interrupt event and mask
 * registers, each with a set address and a clear address, behind an APB
 * slave, plus the two summary flags for the main interrupt event register.
 * Assumes the context completion inputs are synchronous to pclk.
 */
`include "icir_params.svh"

module icir_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [`ICIR_NUM_TX-1:0] tx_done,
    input wire logic [`ICIR_NUM_RX-1:0] rx_done,
    output logic tx_summary_flag,
    output logic rx_summary_flag,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    icir_pkg::icir_apb_req_s req;
    icir_pkg::icir_tx_t tx_evt_ff;
    icir_pkg::icir_tx_t tx_msk_ff;
    icir_pkg::icir_rx_t rx_evt_ff;
    icir_pkg::icir_rx_t rx_msk_ff;
    icir_pkg::icir_tx_t tx_done_ff;
    icir_pkg::icir_rx_t rx_done_ff;
    icir_pkg::icir_tx_t tx_rise;
    icir_pkg::icir_rx_t rx_rise;
    icir_pkg::icir_summary_s nxt_summary;
    logic [`ICIR_IRQ_W-1:0] irq_stat_ff;
    logic [`ICIR_IRQ_W-1:0] irq_mask_ff;
    logic [`ICIR_IRQ_W-1:0] irq_evt;
    logic [`ICIR_IRQ_W-1:0] irq_stat_next;
    logic access;
    logic wr;
    logic rd;
    logic hit;
    logic [31:0] nxt_prdata;
    logic [31:0] wmask;

    assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr,
                   wdata: pwdata};
    // Single-cycle access phase: every transfer completes at its first
    // access edge, so pready is held high.
    assign access = req.sel && req.enable;
    assign wr = access && req.write;
    assign rd = access && !req.write;
    assign wmask = req.wdata;

    ////////////////////////////////////////////////////////////////////////
    // Completion edge detection per context.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_done_ff <= `ICIR_RST_TX;
            rx_done_ff <= `ICIR_RST_RX;
        end else begin
            tx_done_ff <= tx_done;
            rx_done_ff <= rx_done;
        end
    end

    assign tx_rise = tx_done & ~tx_done_ff;
    assign rx_rise = rx_done & ~rx_done_ff;

    ////////////////////////////////////////////////////////////////////////
    // Event and mask bits, one generate slice per context. Hardware set
    // wins over a software clear in the same cycle so no event is lost.
    // Undefined reset values are resolved to zero here.
    genvar gi;
    generate
        for (gi = 0; gi < `ICIR_NUM_TX; gi++) begin : g_tx
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    tx_evt_ff[gi] <= 1'b0;
                end else if (tx_rise[gi]) begin
                    tx_evt_ff[gi] <= 1'b1;
                end else if (wr && req.addr == `ICIR_OFF_TX_EVT_SET && wmask[gi]) begin
                    tx_evt_ff[gi] <= 1'b1;
                end else if (wr && req.addr == `ICIR_OFF_TX_EVT_CLR && wmask[gi]) begin
                    tx_evt_ff[gi] <= 1'b0;
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    tx_msk_ff[gi] <= 1'b0;
                end else if (wr && req.addr == `ICIR_OFF_TX_MSK_SET && wmask[gi]) begin
                    tx_msk_ff[gi] <= 1'b1;
                end else if (wr && req.addr == `ICIR_OFF_TX_MSK_CLR && wmask[gi]) begin
                    tx_msk_ff[gi] <= 1'b0;
                end
            end
        end
        for (gi = 0; gi < `ICIR_NUM_RX; gi++) begin : g_rx
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rx_evt_ff[gi] <= 1'b0;
                end else if (rx_rise[gi]) begin
                    rx_evt_ff[gi] <= 1'b1;
                end else if (wr && req.addr == `ICIR_OFF_RX_EVT_SET && wmask[gi]) begin
                    rx_evt_ff[gi] <= 1'b1;
                end else if (wr && req.addr == `ICIR_OFF_RX_EVT_CLR && wmask[gi]) begin
                    rx_evt_ff[gi] <= 1'b0;
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rx_msk_ff[gi] <= 1'b0;
                end else if (wr && req.addr == `ICIR_OFF_RX_MSK_SET && wmask[gi]) begin
                    rx_msk_ff[gi] <= 1'b1;
                end else if (wr && req.addr == `ICIR_OFF_RX_MSK_CLR && wmask[gi]) begin
                    rx_msk_ff[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Summary flags, computed from the next register values so the outputs
    // track the event and mask bits with no added latency, loading at the same edge.
    icir_pkg::icir_tx_t tx_evt_n;
    icir_pkg::icir_rx_t rx_evt_n;
    icir_pkg::icir_tx_t tx_msk_n;
    icir_pkg::icir_rx_t rx_msk_n;

    always_comb begin
        tx_evt_n = tx_evt_ff;
        tx_msk_n = tx_msk_ff;
        rx_evt_n = rx_evt_ff;
        rx_msk_n = rx_msk_ff;
        if (wr && req.addr == `ICIR_OFF_TX_EVT_CLR) begin
            tx_evt_n = tx_evt_n & ~wmask[`ICIR_NUM_TX-1:0];
        end
        if (wr && req.addr == `ICIR_OFF_TX_EVT_SET) begin
            tx_evt_n = tx_evt_n | wmask[`ICIR_NUM_TX-1:0];
        end
        tx_evt_n = tx_evt_n | tx_rise;
        if (wr && req.addr == `ICIR_OFF_TX_MSK_SET) begin
            tx_msk_n = tx_msk_n | wmask[`ICIR_NUM_TX-1:0];
        end
        if (wr && req.addr == `ICIR_OFF_TX_MSK_CLR) begin
            tx_msk_n = tx_msk_n & ~wmask[`ICIR_NUM_TX-1:0];
        end
        if (wr && req.addr == `ICIR_OFF_RX_EVT_CLR) begin
            rx_evt_n = rx_evt_n & ~wmask[`ICIR_NUM_RX-1:0];
        end
        if (wr && req.addr == `ICIR_OFF_RX_EVT_SET) begin
            rx_evt_n = rx_evt_n | wmask[`ICIR_NUM_RX-1:0];
        end
        rx_evt_n = rx_evt_n | rx_rise;
        if (wr && req.addr == `ICIR_OFF_RX_MSK_SET) begin
            rx_msk_n = rx_msk_n | wmask[`ICIR_NUM_RX-1:0];
        end
        if (wr && req.addr == `ICIR_OFF_RX_MSK_CLR) begin
            rx_msk_n = rx_msk_n & ~wmask[`ICIR_NUM_RX-1:0];
        end
        nxt_summary.tx = |(tx_evt_n & tx_msk_n);
        nxt_summary.rx = |(rx_evt_n & rx_msk_n);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_summary_flag <= 1'b0;
            rx_summary_flag <= 1'b0;
        end else begin
            tx_summary_flag <= nxt_summary.tx;
            rx_summary_flag <= nxt_summary.rx;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky status of summary rising edges, cleared by reading it; a new
    // event in the read cycle survives the clear.
    assign irq_evt = {nxt_summary.rx & ~rx_summary_flag, nxt_summary.tx & ~tx_summary_flag};

    always_comb begin
        irq_stat_next = irq_stat_ff;
        if (rd && req.addr == `ICIR_OFF_IRQ_STAT) begin
            irq_stat_next = `ICIR_RST_IRQ;
        end
        irq_stat_next = irq_stat_next | irq_evt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= `ICIR_RST_IRQ;
        end else begin
            irq_stat_ff <= irq_stat_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_ff <= `ICIR_RST_IRQ;
        end else if (wr && req.addr == `ICIR_OFF_IRQ_MASK) begin
            irq_mask_ff <= req.wdata[`ICIR_IRQ_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_next & irq_mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read decode. Read data is registered during the setup phase so it is
    // valid at the access edge.
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        hit = 1'b1;
        unique case (req.addr)
            `ICIR_OFF_TX_EVT_SET: nxt_prdata[`ICIR_NUM_TX-1:0] = tx_evt_ff;
            `ICIR_OFF_TX_EVT_CLR: nxt_prdata[`ICIR_NUM_TX-1:0] = tx_evt_ff & tx_msk_ff;
            `ICIR_OFF_TX_MSK_SET,
            `ICIR_OFF_TX_MSK_CLR: nxt_prdata[`ICIR_NUM_TX-1:0] = tx_msk_ff;
            // clear read gives event AND mask
            // receive flags in low four bits
            `ICIR_OFF_RX_EVT_SET: nxt_prdata[`ICIR_NUM_RX-1:0] = rx_evt_ff;
            `ICIR_OFF_RX_EVT_CLR: nxt_prdata[`ICIR_NUM_RX-1:0] = rx_evt_ff & rx_msk_ff;
            `ICIR_OFF_RX_MSK_SET,
            `ICIR_OFF_RX_MSK_CLR: nxt_prdata[`ICIR_NUM_RX-1:0] = rx_msk_ff;
            `ICIR_OFF_IRQ_STAT: nxt_prdata[`ICIR_IRQ_W-1:0] = irq_stat_ff;
            `ICIR_OFF_IRQ_MASK: nxt_prdata[`ICIR_IRQ_W-1:0] = irq_mask_ff;
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (req.sel && !req.enable) begin
            prdata <= req.write ? 32'h0000_0000 : nxt_prdata;
            pslverr <= !hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
        end
    end

endmodule

// ==== tb/icir_regs_properties.sv ====
/* Assertions on the ports of the isochronous context interrupt registers.
   Assumes the bind below and APB transfers that keep to the protocol. */
`include "icir_params.svh"

module icir_regs_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [`ICIR_NUM_TX-1:0] tx_done,
    input wire logic [`ICIR_NUM_RX-1:0] rx_done,
    input wire logic tx_summary_flag,
    input wire logic rx_summary_flag,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc, rd, wr;
    assign acc = psel && penable;
    assign rd = acc && !pwrite;
    assign wr = acc && pwrite;
    ////////////////////////////////////////////////////////////////////////////////
    // Summaries load at the same edge as the event bits, so the cause is one edge back.
    // address decode
    decode_map_a: assert property (acc |-> pslverr == !(paddr[1:0] == 2'h0 &&
        paddr inside {[8'h90:8'hac], 8'hc0, 8'hc4})) else $error("decode mismatch");
    unmapped_zero_a: assert property (rd && pslverr |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (rd |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    rx_width_a: assert property (rd && paddr inside {8'ha0, 8'ha4, 8'ha8, 8'hac}
        |-> prdata[31:4] == 28'h0) else $error("receive read too wide");
    rx_rise_a: assert property ($rose(rx_summary_flag) |->
        $past(wr && paddr inside {8'ha0, 8'ha8}) || |($past(rx_done) & ~$past(rx_done, 2)))
        else $error("receive summary rose without cause");
    rx_fall_a: assert property ($fell(rx_summary_flag) |->
        $past(wr && paddr inside {8'ha4, 8'hac})) else $error("receive summary fell alone");
    tx_rise_a: assert property ($rose(tx_summary_flag) |->
        $past(wr && paddr inside {8'h90, 8'h98}) || |($past(tx_done) & ~$past(tx_done, 2)))
        else $error("transmit summary rose without cause");
    tx_fall_a: assert property ($fell(tx_summary_flag) |->
        $past(wr && paddr inside {8'h94, 8'h9c})) else $error("transmit summary fell alone");
    irq_rise_a: assert property ($rose(irq) |-> $rose(tx_summary_flag) ||
        $rose(rx_summary_flag) || $past(wr && paddr == 8'hc4) || $past(wr && paddr == 8'hc4, 2))
        else $error("interrupt rose without cause");
    cover property ($rose(rx_summary_flag));
    cover property ($fell(tx_summary_flag));
    cover property ($rose(irq));
    cover property (acc && pslverr);
endmodule

bind icir_regs icir_regs_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .tx_done, .rx_done, .tx_summary_flag,
    .rx_summary_flag, .irq);

// ==== tb/tb_top.sv ====
/* Self-checking bench for the isochronous context interrupt registers.
   Assumes an APB slave whose summaries settle within three clocks. */
`include "icir_params.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [7:0] wa;
        logic [31:0] wd;
        logic [7:0] ra;
        logic [31:0] rv;
        logic [1:0] sum;
    } icir_row_s;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, tx_summary_flag, rx_summary_flag, irq;
    logic [`ICIR_NUM_TX-1:0] tx_done = 8'h00;
    logic [`ICIR_NUM_RX-1:0] rx_done = 4'h0;
    int error_cnt = 0;
    int n_tests = 0;
    icir_row_s rows [11];
    always #20 pclk = ~pclk;
    icir_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .tx_done, .rx_done, .tx_summary_flag, .rx_summary_flag, .irq);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Idles one cycle between transfers so no signal is driven twice in a step.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            error_cnt++;
            give_verdict();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle();
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rows = '{
            '{8'h98, 32'hffffff5a, 8'h98, 32'h0000005a, 2'h0},
            '{8'h9c, 32'h00000042, 8'h9c, 32'h00000018, 2'h0},
            '{8'h90, 32'hffffffff, 8'h90, 32'h000000ff, 2'h1},
            '{8'h94, 32'h00000000, 8'h94, 32'h00000018, 2'h1},
            '{8'h94, 32'h000000f7, 8'h90, 32'h00000008, 2'h1},
            '{8'h9c, 32'h00000008, 8'h94, 32'h00000000, 2'h0},
            '{8'ha8, 32'hfffffff6, 8'hac, 32'h00000006, 2'h0},
            '{8'ha0, 32'h00000009, 8'ha0, 32'h00000009, 2'h0},
            '{8'ha0, 32'h00000002, 8'ha4, 32'h00000002, 2'h2},
            '{8'ha4, 32'h0000000b, 8'ha0, 32'h00000000, 2'h0},
            '{8'hb0, 32'hffffffff, 8'hb0, 32'h00000000, 2'h0}};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, rows[i].wa, rows[i].wd);
            apb(1'b0, rows[i].ra, 32'h0);
            settle();
            chk(rd, rows[i].rv);
            chk({30'h0, rx_summary_flag, tx_summary_flag}, {30'h0, rows[i].sum});
        end
        // Both summaries rose above while the interrupt mask was still clear.
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, 8'hc0, 32'h0);
        chk(rd, 32'h3);
        apb(1'b0, 8'hc0, 32'h0);
        chk(rd, 32'h0);
        @(posedge pclk);
        rx_done <= 4'h2;
        settle();
        chk({31'h0, rx_summary_flag}, 32'h1);
        // Software finds the interrupting receive context after the summary.
        apb(1'b0, 8'ha0, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, 8'hc4, 32'h2);
        settle();
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, 8'hc0, 32'h0);
        settle();
        chk(rd, 32'h2);
        chk({31'h0, irq}, 32'h0);
        // A completion level held high must not set the flag again once cleared.
        apb(1'b1, 8'ha4, 32'h2);
        apb(1'b0, 8'ha0, 32'h0);
        settle();
        chk(rd, 32'h0);
        chk({31'h0, rx_summary_flag}, 32'h0);
        @(posedge pclk);
        rx_done <= 4'h0;
        tx_done <= 8'h10;
        @(posedge pclk);
        tx_done <= 8'h00;
        settle();
        chk({31'h0, tx_summary_flag}, 32'h1);
        apb(1'b0, 8'h94, 32'h0);
        chk(rd, 32'h10);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        chk({30'h0, rx_summary_flag, tx_summary_flag}, 32'h0);
        apb(1'b0, 8'h98, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'ha0, 32'h0);
        chk(rd, 32'h0);
        give_verdict();
    end
endmodule
